// ### core/chgsup_pkg.sv
// Shared constants, encodings and helpers of the charger supervisor
package chgsup_pkg;
  // Clock and reference tick
  localparam int CLK_HZ        = 20_000_000;
  localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYC_DEF  = CYC_PER_US * TICK_US;
  // Interrupt pulse width
  localparam int PULSE_US      = 256;
  localparam int PULSE_CYC_DEF = CYC_PER_US * PULSE_US;
  // Minute built from reference ticks
  localparam int MIN_S         = 60;
  localparam int MIN_TICKS_DEF = MIN_S * 1_000_000 / TICK_US;
  // Protection and timer durations
  localparam int LOWBAT_HR     = 4;
  localparam int USB_MIN       = 45;
  localparam int HICCUP_MS     = 20;
  localparam int SHORT_MS      = 1;
  localparam int BLINK_HZ      = 1;
  localparam int HICCUP_TICKS  = HICCUP_MS * 1000 / TICK_US;
  localparam int SHORT_TICKS   = SHORT_MS * 1000 / TICK_US;
  localparam int BLINK_TICKS   = 1_000_000 / (2 * BLINK_HZ * TICK_US);
  localparam int OC_EVENTS     = 16;
  // Fast-charge timer hours per field code (arbitrary plain defaults)
  localparam int SAFE_HR_0     = 5;
  localparam int SAFE_HR_1     = 8;
  localparam int SAFE_HR_2     = 12;
  localparam int SAFE_HR_3     = 20;
  localparam int HALF_PER_HR   = 2 * 60;
  // Fault register layout
  localparam int FR_W          = 8;
  localparam int FR_BOOST      = 6;
  localparam int FR_TYPE_HI    = 5;
  localparam int FR_TYPE_LO    = 4;
  localparam int FR_BAT        = 3;
  localparam int FR_TS_HI      = 2;
  localparam int FR_TS_LO      = 0;
  localparam logic [1:0] FT_NONE  = 2'h0;
  localparam logic [1:0] FT_INOVP = 2'h1;
  localparam logic [1:0] FT_TSD   = 2'h2;
  localparam logic [1:0] FT_TIMER = 2'h3;
  // Charge configuration field
  localparam logic [1:0] CONF_OFF = 2'h0;
  localparam logic [1:0] CONF_CHG = 2'h1;

  typedef logic [15:0] chgsup_half_t;

  // Safety timer limit in half-minute units
  function automatic chgsup_half_t safe_limit(input logic [1:0] code, input logic low_bat);
    int hrs;
    hrs = (code == 2'h0) ? SAFE_HR_0 : (code == 2'h1) ? SAFE_HR_1 : (code == 2'h2) ? SAFE_HR_2 : SAFE_HR_3;
    if (low_bat) hrs = LOWBAT_HR;
    return chgsup_half_t'(hrs * HALF_PER_HR);
  endfunction : safe_limit
endpackage : chgsup_pkg

// ### core/chgsup_sync.sv
// Two-flop synchroniser for a vector of pin levels
module chgsup_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  if (W < 1) begin : g_chk
    $error("chgsup_sync width must be positive");
  end

  // First stage read only by the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : chgsup_sync

// ### core/chgsup_pulse.sv
// Fixed-width active-low pulse with one pending request
module chgsup_pulse #(
  parameter int PULSE_CYC = chgsup_pkg::PULSE_CYC_DEF
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic fire,
  output logic      pulse_n
);
  localparam int CW = $clog2(PULSE_CYC + 1);
  logic [CW-1:0] cnt_ff;
  logic          pend_ff;
  logic          busy;
  logic          start;

  if (PULSE_CYC < 2) begin : g_chk
    $error("chgsup_pulse needs at least two cycles");
  end

  assign busy  = (cnt_ff != '0);
  assign start = !busy && (fire || pend_ff);

  // Running pulse is never cut short; extra events queue one more
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      pend_ff <= 1'b0;
      pulse_n <= 1'b1;
    end else begin
      cnt_ff  <= start ? CW'(PULSE_CYC) : (busy ? cnt_ff - 1'b1 : cnt_ff);
      pend_ff <= busy ? (pend_ff || fire) : 1'b0;
      pulse_n <= !(start || (busy && cnt_ff != CW'(1)));
    end
  end

  // Low phase length checker
  logic [CW:0] low_len_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) low_len_ff <= '0;
    else       low_len_ff <= pulse_n ? '0 : low_len_ff + 1'b1;
  end

  a_pulse_width: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(pulse_n) |-> low_len_ff == (CW + 1)'(PULSE_CYC))
    else $error("interrupt pulse width wrong");
endmodule : chgsup_pulse

// ### core/chgsup_top.sv
// Charger supervisor: safety timer, status pins, fault latch and protections
module chgsup_top #(
  parameter int TICK_CYC  = chgsup_pkg::TICK_CYC_DEF,
  parameter int MIN_TICKS = chgsup_pkg::MIN_TICKS_DEF,
  parameter int PULSE_CYC = chgsup_pkg::PULSE_CYC_DEF
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire logic                         vin_uvlo_ok,
  input  wire logic                         vin_above_bat,
  input  wire logic                         vin_below_acov,
  input  wire logic                         vin_min_ok,
  input  wire logic                         vin_ovp,
  input  wire logic                         system_overvoltage,
  input  wire logic                         vbat_low,
  input  wire logic                         vbat_short,
  input  wire logic                         vbat_ovp,
  input  wire logic                         input_regulation,
  input  wire logic                         therm_reg,
  input  wire logic                         therm_shdn,
  input  wire logic                         boost_mode,
  input  wire logic                         boost_peak_oc,
  input  wire logic                         boost_below_bat,
  input  wire logic                         sys_short,
  input  wire logic                         src_ident,
  input  wire logic                         usb100_src,
  input  wire logic                         chg_done,
  input  wire logic                         charge_off_pin,
  input  wire logic [2:0]                   ts_fault,
  input  wire logic [2:0]                   hw_current_cap_pin,
  input  wire logic [1:0]                   chg_conf,
  input  wire logic                         timer_en,
  input  wire logic [1:0]                   timer_code,
  input  wire logic                         half_rate_en,
  input  wire logic [2:0]                   iin_lim_code,
  input  wire logic                         term_en,
  input  wire logic                         fault_rd,
  output logic                              power_good_out_n,
  output logic                              stat_out,
  output logic                              stat_oe_n,
  output logic                              int_n,
  output logic [chgsup_pkg::FR_W-1:0]       fault_reg,
  output logic                              therm_reg_status,
  output logic                              chg_enable,
  output logic                              converter_on,
  output logic                              hiz_mode,
  output logic                              battery_path_switch,
  output logic                              trickle_100ma,
  output logic                              term_allowed,
  output logic [2:0]                        iin_lim_eff
);
  import chgsup_pkg::*;

  typedef enum logic [1:0] {TM_IDLE, TM_RUN, TM_EXP} chgsup_tm_e;
  typedef enum logic       {BS_RUN, BS_OFF} chgsup_bs_e;

  localparam int NS  = 26;
  localparam int TCW = $clog2(TICK_CYC + 1);
  localparam int MCW = $clog2(MIN_TICKS + 1);

  if (TICK_CYC < 1 || MIN_TICKS < 1 || PULSE_CYC < 2) begin : g_chk
    $error("chgsup_top timing parameters out of range");
  end

  // Pin synchronisation and previous-value capture
  logic [NS-1:0] raw, s, prv_ff;
  assign raw = {vin_uvlo_ok, vin_above_bat, vin_below_acov, vin_min_ok, vin_ovp, system_overvoltage,
                vbat_low, vbat_short, vbat_ovp, input_regulation, therm_reg, therm_shdn, boost_mode,
                boost_peak_oc, boost_below_bat, sys_short, src_ident, usb100_src, chg_done,
                charge_off_pin, ts_fault, hw_current_cap_pin};

  chgsup_sync #(.W(NS)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (raw),
    .dout    (s)
  );

  logic uvlo_s, abov_s, acov_s, vmin_s, ovp_s, sovp_s, blow_s, bshort_s, bovp_s, inreg_s;
  logic treg_s, tsd_s, bst_s, oc_s, bbb_s, sshort_s, ident_s, usb_s, done_s, coff_s;
  logic [2:0] ts_s, cap_s;
  assign {uvlo_s, abov_s, acov_s, vmin_s, ovp_s, sovp_s, blow_s, bshort_s, bovp_s, inreg_s,
          treg_s, tsd_s, bst_s, oc_s, bbb_s, sshort_s, ident_s, usb_s, done_s, coff_s,
          ts_s, cap_s} = s;

  logic [NS-1:0] rise;
  assign rise = s & ~prv_ff;
  logic uvlo_rise, uvlo_fall, ovp_rise, tsd_rise, bovp_rise, sshort_rise, coff_rise;
  logic ident_rise, done_rise, oc_rise, ts_rise;
  assign uvlo_rise   = rise[NS-1];
  assign uvlo_fall   = prv_ff[NS-1] && !uvlo_s;
  assign ovp_rise    = rise[NS-5];
  assign bovp_rise   = rise[NS-9];
  assign tsd_rise    = rise[NS-12];
  assign oc_rise     = rise[NS-14];
  assign sshort_rise = rise[NS-16];
  assign ident_rise  = rise[NS-17];
  assign done_rise   = rise[NS-19];
  assign coff_rise   = rise[NS-20];                                                 // high after low
  assign ts_rise     = (ts_s != 3'h0) && (prv_ff[5:3] == 3'h0);

  // Reference tick and minute tick
  logic [TCW-1:0] tick_cnt_ff;
  logic [MCW-1:0] min_cnt_ff;
  logic ms_tick, min_tick;
  assign ms_tick  = (tick_cnt_ff == TCW'(TICK_CYC - 1));
  assign min_tick = ms_tick && (min_cnt_ff == MCW'(MIN_TICKS - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
      min_cnt_ff  <= '0;
      prv_ff      <= '0;
    end else begin
      tick_cnt_ff <= ms_tick ? '0 : tick_cnt_ff + 1'b1;
      min_cnt_ff  <= min_tick ? '0 : (ms_tick ? min_cnt_ff + 1'b1 : min_cnt_ff);
      prv_ff      <= s;
    end
  end

  // Register-side edge capture
  logic [1:0] conf_prv_ff;
  logic       ten_prv_ff;
  logic       conf_step, ten_rise, restart;
  assign conf_step = (conf_prv_ff == CONF_OFF) && (chg_conf == CONF_CHG);
  assign ten_rise  = timer_en && !ten_prv_ff;
  assign restart   = coff_rise || conf_step || ten_rise;

  // Power good and converter state
  logic pg_ok, hiz_ff, bs_run;
  chgsup_bs_e bs_ff, nxt_bs;
  assign pg_ok  = uvlo_s && abov_s && acov_s && vmin_s;
  assign bs_run = (bs_ff == BS_RUN);

  // Charge enable and activity
  chgsup_tm_e tm_ff, nxt_tm;
  logic chg_ok, chg_active;
  assign chg_ok = (chg_conf == CONF_CHG) && !coff_s && (ts_s == 3'h0) && (tm_ff != TM_EXP)
                  && !bovp_s && !hiz_ff && pg_ok && !ovp_s && !tsd_s && !bst_s;
  assign chg_active = chg_ok && !done_s;

  // Safety timer limit, step and expiry
  chgsup_half_t tm_cnt_ff, tm_lim;
  logic half, tm_hit;
  assign tm_lim = safe_limit(timer_code, blow_s);
  assign half   = (inreg_s || treg_s) && half_rate_en;
  assign tm_hit = (tm_ff == TM_RUN) && timer_en && chg_active && (tm_cnt_ff >= tm_lim);

  always_comb begin
    nxt_tm = tm_ff;
    case (tm_ff)
      TM_IDLE: if (timer_en && chg_active) nxt_tm = TM_RUN;
      TM_RUN:  if (!timer_en || !chg_active) nxt_tm = TM_IDLE;
               else if (tm_hit) nxt_tm = TM_EXP;
      TM_EXP:  if (!timer_en || restart) nxt_tm = TM_IDLE;
      default: nxt_tm = TM_IDLE;
    endcase
  end

  // Timer state and count in half-minute units
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tm_ff       <= TM_IDLE;
      tm_cnt_ff   <= '0;
      conf_prv_ff <= CONF_OFF;
      ten_prv_ff  <= 1'b0;
    end else begin
      tm_ff       <= nxt_tm;
      tm_cnt_ff   <= (nxt_tm != TM_RUN) ? '0 :
                     (min_tick ? tm_cnt_ff + (half ? 16'h0001 : 16'h0002) : tm_cnt_ff);
      conf_prv_ff <= chg_conf;
      ten_prv_ff  <= timer_en;
    end
  end

  // USB 100 mA default-mode timer
  logic [5:0] usb_cnt_ff;
  logic usb_hit;
  assign usb_hit = usb_s && chg_active && min_tick && (usb_cnt_ff == 6'(USB_MIN - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      usb_cnt_ff <= '0;
      hiz_ff     <= 1'b0;
    end else begin
      usb_cnt_ff <= (!usb_s || !chg_active) ? '0 : (min_tick ? usb_cnt_ff + 1'b1 : usb_cnt_ff);
      hiz_ff     <= usb_hit || (hiz_ff && !uvlo_rise);
    end
  end

  // Boost hiccup protection
  logic [4:0] oc_cnt_ff;
  logic [4:0] hic_cnt_ff;
  logic bst_trip, hic_done;
  assign bst_trip = bst_s && bs_run &&
                    ((oc_rise && oc_cnt_ff == 5'(OC_EVENTS - 1)) || bbb_s);
  assign hic_done = ms_tick && (hic_cnt_ff == 5'(HICCUP_TICKS - 1));

  always_comb begin
    nxt_bs = bs_ff;
    case (bs_ff)
      BS_RUN:  if (bst_trip) nxt_bs = BS_OFF;
      BS_OFF:  if (hic_done) nxt_bs = BS_RUN;                                       // retry
      default: nxt_bs = BS_RUN;
    endcase
  end

  // Consecutive events are those within one reference tick
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bs_ff      <= BS_RUN;
      oc_cnt_ff  <= '0;
      hic_cnt_ff <= '0;
    end else begin
      bs_ff      <= nxt_bs;
      oc_cnt_ff  <= (!bs_run || bst_trip || ms_tick) ? '0 : (oc_rise ? oc_cnt_ff + 1'b1 : oc_cnt_ff);
      hic_cnt_ff <= (bs_run || hic_done) ? '0 : (ms_tick ? hic_cnt_ff + 1'b1 : hic_cnt_ff);
    end
  end

  // Battery short and system short path control
  logic [4:0] sh_cnt_ff;
  logic path_lat_ff, sh_wait;
  assign sh_wait = bshort_s && (sh_cnt_ff < 5'(SHORT_TICKS));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh_cnt_ff   <= '0;
      path_lat_ff <= 1'b0;
    end else begin
      sh_cnt_ff   <= !bshort_s ? '0 : ((sh_wait && ms_tick) ? sh_cnt_ff + 1'b1 : sh_cnt_ff);
      path_lat_ff <= sshort_rise || sshort_s || (path_lat_ff && !uvlo_rise);
    end
  end

  // Fault register next value
  logic [1:0] ft_q, nxt_ft;
  logic bstf_q, batf_q;
  logic fault_evt;
  assign nxt_ft = tsd_rise ? FT_TSD :
                  ovp_rise ? FT_INOVP :
                  tm_hit   ? FT_TIMER :
                  fault_rd ? FT_NONE : ft_q;
  assign fault_evt = tsd_rise || ovp_rise || tm_hit || bst_trip || bovp_rise || ts_rise;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ft_q   <= FT_NONE;
      bstf_q <= 1'b0;
      batf_q <= 1'b0;
    end else begin
      ft_q   <= nxt_ft;
      bstf_q <= bst_trip || (bstf_q && !fault_rd);                                  // set wins
      batf_q <= bovp_rise || (batf_q && !fault_rd);                                 // set wins
    end
  end

  // Interrupt event collection
  logic irq_fire, pg_rise;
  assign pg_rise  = pg_ok && power_good_out_n;
  assign irq_fire = ident_rise || pg_rise || uvlo_fall || ovp_rise || done_rise || fault_evt;

  chgsup_pulse #(.PULSE_CYC(PULSE_CYC)) u_pulse (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .fire    (irq_fire),
    .pulse_n (int_n)
  );

  // Status pin blink and suspend decode
  logic [8:0] blink_cnt_ff;
  logic blink_ff, suspend;
  assign suspend = (tm_ff == TM_EXP) || (ts_s != 3'h0) || ovp_s || sovp_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else if (ms_tick) begin
      blink_cnt_ff <= (blink_cnt_ff == 9'(BLINK_TICKS - 1)) ? '0 : blink_cnt_ff + 1'b1;
      blink_ff     <= (blink_cnt_ff == 9'(BLINK_TICKS - 1)) ? !blink_ff : blink_ff;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_good_out_n    <= 1'b1;
      stat_out            <= 1'b0;
      stat_oe_n           <= 1'b1;
      fault_reg           <= '0;
      therm_reg_status    <= 1'b0;
      chg_enable          <= 1'b0;
      converter_on        <= 1'b0;
      hiz_mode            <= 1'b0;
      battery_path_switch <= 1'b0;
      trickle_100ma       <= 1'b0;
      term_allowed        <= 1'b0;
      iin_lim_eff         <= '0;
    end else begin
      power_good_out_n    <= !pg_ok;
      stat_out            <= 1'b0;
      stat_oe_n           <= suspend ? blink_ff : !chg_active;
      fault_reg[FR_W-1]   <= 1'b0;
      fault_reg[FR_BOOST] <= bstf_q;
      fault_reg[FR_TYPE_HI:FR_TYPE_LO] <= ft_q;
      fault_reg[FR_BAT]   <= batf_q;
      fault_reg[FR_TS_HI:FR_TS_LO] <= ts_s;                                         // live
      therm_reg_status    <= treg_s;
      chg_enable          <= chg_ok;
      converter_on        <= !tsd_s && (bst_s ? bs_run : (pg_ok && !ovp_s && !sovp_s && !hiz_ff));
      hiz_mode            <= hiz_ff;
      battery_path_switch <= !path_lat_ff && !sh_wait;
      trickle_100ma       <= bshort_s && !sh_wait;
      term_allowed        <= term_en && !treg_s && !inreg_s;
      iin_lim_eff         <= (cap_s < iin_lim_code) ? cap_s : iin_lim_code;
    end
  end

  a_timer_expire_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    tm_hit && !tsd_rise && !ovp_rise |=> ##1
    fault_reg[FR_TYPE_HI:FR_TYPE_LO] == FT_TIMER)
    else $error("timer expiry not reported as type 11");

  a_timer_disabled: assert property (@(posedge sys_clk) disable iff (!rstn)
    !timer_en |=> tm_cnt_ff == '0 && tm_ff == TM_IDLE)
    else $error("safety timer active while disabled");

  a_half_rate_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    tm_ff == TM_RUN && nxt_tm == TM_RUN && min_tick && half |=> tm_cnt_ff == $past(tm_cnt_ff) + 16'h0001)
    else $error("timer not at half rate in regulation");

  a_power_good: assert property (@(posedge sys_clk) disable iff (!rstn)
    !power_good_out_n |-> $past(uvlo_s) && $past(abov_s) && $past(acov_s) && $past(vmin_s))
    else $error("power good low without valid input");

  a_stat_charging: assert property (@(posedge sys_clk) disable iff (!rstn)
    chg_active && !suspend |=> !stat_oe_n && !stat_out)
    else $error("status pin not low while charging");

  a_hiccup_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    bst_trip && !tsd_s |=> bstf_q ##1 (!bs_run)[*7])
    else $error("boost hiccup did not hold converter off");

  a_fault_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    batf_q && !fault_rd |=> batf_q)
    else $error("battery fault lost before read");

  a_bat_ovp_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    bovp_s |=> !chg_enable)
    else $error("charging enabled during battery over-voltage");

  a_input_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> iin_lim_eff <= $past(cap_s) && iin_lim_eff <= $past(iin_lim_code))
    else $error("input limit above a cap");

  a_sys_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    path_lat_ff && !uvlo_rise |=> !battery_path_switch ##1 !battery_path_switch)
    else $error("path switch on during latch-off");
endmodule : chgsup_top

// ### tb/chgsup_host.sv
// Host model that reads the fault register on request
module chgsup_host (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic rd_req,
  output logic      fault_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_ff;
  // One-cycle read strobe per request rise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_ff   <= 1'b0;
      fault_rd <= 1'b0;
    end else begin
      req_ff   <= rd_req;
      fault_rd <= rd_req & ~req_ff;
    end
  end
endmodule : chgsup_host

// ### tb/chgsup_top_test.sv
// Self-checking bench of the charger supervisor
module chgsup_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rstn = 0, vin_uvlo_ok = 0, vin_above_bat = 0, vin_below_acov = 0, vin_min_ok = 0, vin_ovp = 0;
  logic system_overvoltage = 0, vbat_low = 0, vbat_short = 0, vbat_ovp = 0, input_regulation = 0, therm_reg = 0;
  logic therm_shdn = 0, boost_mode = 0, boost_peak_oc = 0, boost_below_bat = 0, sys_short = 0, src_ident = 0;
  logic usb100_src = 0, chg_done = 0, charge_off_pin = 0, timer_en = 0, half_rate_en = 1, term_en = 1, rd_req = 0;
  logic [2:0] ts_fault = 0, hw_current_cap_pin = 0, iin_lim_code = 0, iin_lim_eff;
  logic [1:0] chg_conf = 0, timer_code = 0;
  logic [7:0] fault_reg;
  logic fault_rd, power_good_out_n, stat_out, stat_oe_n, int_n, therm_reg_status, chg_enable, converter_on;
  logic hiz_mode, battery_path_switch, trickle_100ma, term_allowed;
  logic [31:0] seed = 39;
  int n_mismatch = 0, n_tests = 0, cyc = 0, n;
  chgsup_top #(.TICK_CYC(4), .MIN_TICKS(3), .PULSE_CYC(8)) chgsup_top_inst (.*);
  chgsup_host chgsup_host_inst (.sys_clk(sys_clk), .rstn(rstn), .rd_req(rd_req), .fault_rd(fault_rd));
  // Clock and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 9000) begin
      n_mismatch++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [2:0] lo3(input logic [2:0] a, input logic [2:0] b);
    return (a < b) ? a : b;
  endfunction : lo3
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : wt
  // Read faults and let pulses drain
  task automatic clr();
    wt(30);
    rd_req = 1;
    wt(3);
    rd_req = 0;
    wt(3);
  endtask : clr
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Random pin phase, then corner scenarios
  initial begin
    wt(4);
    rstn = 1;
    wt(3);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      if (i % 8 == 0) seed[3:0] = 4'hF;
      {vin_uvlo_ok, vin_above_bat, vin_below_acov, vin_min_ok} = seed[3:0];
      {ts_fault, hw_current_cap_pin, iin_lim_code} = seed[12:4];
      {boost_mode, boost_peak_oc, boost_below_bat, sys_short, src_ident} = seed[17:13];
      {chg_done, usb100_src, vbat_short, system_overvoltage, input_regulation} = seed[22:18];
      wt(4);
      chk("pg", {7'h0, ~&seed[3:0]}, power_good_out_n);
      chk("hw_current_cap_pin", lo3(hw_current_cap_pin, iin_lim_code), iin_lim_eff);
      chk("ts", ts_fault, fault_reg[2:0]);
    end
    {ts_fault, boost_mode, boost_peak_oc, boost_below_bat, sys_short, input_regulation} = 0;
    {src_ident, chg_done, usb100_src, vbat_short, system_overvoltage} = 0;
    {vin_uvlo_ok, vin_above_bat, vin_below_acov, vin_min_ok} = 4'hF;
    clr();
    vbat_ovp = 1;
    wt(3);
    chk("batovp", 8'h00, {fault_reg[3], 3'h0, chg_enable, 2'h0, int_n});
    for (n = 0; int_n === 1'b0 && n < 20; n++) wt(1);
    chk("width", 8'h08, n[7:0]);
    vbat_ovp = 0;
    wt(5);
    chk("latch", 8'h01, fault_reg[3]);
    clr();
    chk("cleared", 8'h00, fault_reg[7:3]);
    for (int k = 0; k < 2; k++) begin
      {therm_shdn, vin_ovp} = k ? 2'h1 : 2'h2;
      wt(4);
      chk("ftype", k ? 8'h01 : 8'h02, fault_reg[5:4]);
      chk("conv", 8'h00, converter_on);
      {therm_shdn, vin_ovp} = 0;
      clr();
    end
    therm_reg = 1;
    wt(4);
    chk("treg", 8'h02, {therm_reg_status, term_allowed});
    {therm_reg, chg_conf, charge_off_pin} = 4'h3;
    wt(4);
    chk("off", 8'h00, chg_enable);
    {charge_off_pin, vbat_low, timer_en, timer_code} = {3'h3, seed[1:0]};
    wt(4);
    chk("on", 8'h01, chg_enable);
    chk("stat", 8'h00, stat_oe_n);
    wt(2600);
    chk("early", 8'h00, fault_reg[5:4]);
    for (n = 0; fault_reg[5:4] !== 2'h3 && n < 600; n++) wt(1);
    chk("expiry", 8'h01, n < 600);
    timer_en = 0;
    wt(1);
    timer_en = 1;
    wt(4);
    chk("restart", 8'h01, chg_enable);
    input_regulation = 1;
    wt(30);
    chk("term", 8'h00, term_allowed);
    input_regulation = 0;
    vbat_ovp = 1;
    wt(4);
    chk("batstop", 8'h00, chg_enable);
    sys_short = 1;
    wt(4);
    sys_short = 0;
    wt(4);
    chk("pathoff", 8'h00, battery_path_switch);
    vin_uvlo_ok = 0;
    wt(4);
    {vin_uvlo_ok, vbat_short} = 2'h3;
    wt(12);
    chk("pathon", 8'h03, {battery_path_switch, trickle_100ma});
    end_sim();
  end
endmodule : chgsup_top_test
